// *** rtl/clock_manager_pkg.sv ***
/*
 * Shared constants and carrier types of the clock manager control block:
 * register offsets, writable-bit masks, reset values, field positions and
 * the scale factors of the duty-cycle arithmetic.
 * Assumes an 8-bit register port with a 3-bit word address.
 */
package clock_manager_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [2:0] DIV_OFFSET    = 3'h2;
    localparam logic [2:0] DUTY2X_OFFSET = 3'h3;
    localparam logic [2:0] DUTY1X_OFFSET = 3'h4;
    localparam logic [2:0] MODE_OFFSET   = 3'h5;
    localparam logic [2:0] CTRL_OFFSET   = 3'h7;

    // ************************************************************
    // Writable bits and reset values
    // ************************************************************
    localparam logic [7:0] DIV_RW_MASK      = 8'h8F;
    localparam logic [7:0] MODE_RW_MASK     = 8'h15;
    localparam logic [7:0] CTRL_RW_MASK     = 8'h80;
    localparam logic [7:0] DIV_RESET_VAL    = 8'h00;
    localparam logic [7:0] DUTY2X_RESET_VAL = 8'h00;
    localparam logic [7:0] DUTY1X_RESET_VAL = 8'h00;
    localparam logic [7:0] MODE_RESET_VAL   = 8'h00;
    localparam logic [7:0] CTRL_RESET_VAL   = 8'h00;
    localparam logic [7:0] READ_IDLE_VAL    = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int DIV_VAL_LSB        = 0;
    localparam int DIV_VAL_W          = 4;
    localparam int DIV_RESET_BIT      = 7;
    localparam int MODE_PLL_BIT       = 0;
    localparam int MODE_FB_BIT        = 2;
    localparam int MODE_2X_BIT        = 4;
    localparam int CTRL_GSR_BLOCK_BIT = 7;
    localparam int STEP_LO_LSB        = 0;
    localparam int STEP_HI_LSB        = 3;
    localparam int STEP_W             = 3;
    localparam int FIRST_MASTER_BIT   = 6;
    localparam int SECOND_MASTER_BIT  = 7;
    localparam int MASTER1X_LSB       = 6;
    localparam int MASTER1X_W         = 2;

    // ************************************************************
    // Divider and duty arithmetic
    // ************************************************************
    localparam logic [3:0] DIV_BYPASS    = 4'h0;
    localparam logic [3:0] DIV_WRAP      = 4'h8;
    localparam logic [3:0] DIV_ONE       = 4'h1;
    localparam logic [4:0] HALF_IN_16THS = 5'h08; // 50% in 6.25% steps
    localparam logic [4:0] ONE_16TH      = 5'h01;
    localparam logic [5:0] ONE_32ND      = 6'h01; // 3.125% step

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // High times: doubled clock in 1/16, single clock in 1/32 of a period
    typedef struct packed {
        logic [4:0] first_high;
        logic [4:0] second_high;
        logic [5:0] single_high;
    } duty_type;

endpackage

// *** rtl/duty_decoder.sv ***
/*
 * Combinational decode of the two duty-cycle registers into high times.
 * Assumes the caller registers the result before it leaves the block.
 */
`timescale 1ns/1ps
`default_nettype none

module duty_decoder (
    // Register contents
    input  wire logic [7:0]                duty2x_i,
    input  wire logic [7:0]                duty1x_i,
    // Decoded high times
    output var  clock_manager_pkg::duty_type duty_o
);
    import clock_manager_pkg::*;

    // ************************************************************
    // Step fields and master ranges
    // ************************************************************
    always_comb begin
        logic [2:0] step;
        logic [1:0] master;
        step   = duty1x_i[STEP_LO_LSB +: STEP_W];
        master = duty1x_i[MASTER1X_LSB +: MASTER1X_W];
        duty_o.first_high  = (duty2x_i[FIRST_MASTER_BIT] ?
                              HALF_IN_16THS : 5'h00) + ONE_16TH +
                             {2'h0, duty2x_i[STEP_LO_LSB +: STEP_W]}; // RL6
        duty_o.second_high = (duty2x_i[SECOND_MASTER_BIT] ?
                              HALF_IN_16THS : 5'h00) + ONE_16TH +
                             {2'h0, duty2x_i[STEP_HI_LSB +: STEP_W]}; // RL7
        // Upper master bit means above 50%: the other step field is unused
        if (master[1]) begin
            step = duty1x_i[STEP_HI_LSB +: STEP_W]; // RL11
        end
        duty_o.single_high = {1'b0, master, 3'h0} + {3'h0, step} +
                             ONE_32ND; // RL10
    end

endmodule // duty_decoder

`default_nettype wire

// *** rtl/edge_divider.sv ***
/*
 * Pulse divider for the edge clock: one output pulse per ratio_i ticks.
 * Assumes ratio_i lies in 1 to 8 and tick_i is on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module edge_divider (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       clear_i,
    input  wire logic [3:0] ratio_i,
    // Pulses
    input  wire logic       tick_i,
    output logic            pulse_o
);
    import clock_manager_pkg::*;

    logic [2:0] cnt_ff;
    logic [3:0] last;

    assign last = ratio_i - DIV_ONE;

    // ************************************************************
    // Tick counter
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i || clear_i) begin
            cnt_ff  <= 3'h0;
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= 1'b0;
            if (tick_i) begin
                if ({1'b0, cnt_ff} >= last) begin // RL1
                    cnt_ff  <= 3'h0;
                    pulse_o <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 3'h1;
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    pulse_from_tick_a: assert property ( // RL1
        @(posedge clock_i) disable iff (rst_i)
        pulse_o |-> $past(tick_i) && !$past(clear_i))
        else $error("divider pulse without a tick");

    ratio_one_a: assert property ( // RL1
        @(posedge clock_i) disable iff (rst_i)
        (ratio_i == DIV_ONE && tick_i && !clear_i) |=> pulse_o)
        else $error("divide by one missed a tick");

endmodule // edge_divider

`default_nettype wire

// *** rtl/clock_manager_ctrl_regs.sv ***
/*
 * Control registers of the programmable clock manager: edge clock
 * divider, doubled and single clock duty programming, loop mode select
 * and the global-reset block bit.
 * Assumes a same-clock register master and a same-clock delay line tick;
 * the global set/reset pin is asynchronous and is synchronised here.
 */
// Chosen here: strobed register access.
// Summary of operation
// RL1: Edge clock pulses are divided by the four-bit divider value.
// RL2: Divider value zero bypasses the divider with one cycle less latency.
// RL3: Values above eight divide by the value modulo eight.
// RL4: Divider reset bit forces default value; software clears it to release.
// RL5: Global set/reset clears the divider only when not blocked.
// RL6: Doubled first period high time is bit6 half plus low step.
// RL7: Doubled second period high time is bit7 half plus high step.
// RL8: Bit 6 picks first doubled period at most or above half.
// RL9: Bit 7 picks second doubled period range; C9 gives 62.5% both.
// RL10: Single clock up to half uses quarters plus low step.
// RL11: Single clock above half uses quarters plus high step.
// RL12: Two master bits choose the quarter range of the single clock.
// RL13: The unused step field of the single clock register is ignored.
// RL14: Same register sets output delay up to 31/32 of the period.
// RL15: Mode bit 0 selects delay-locked at zero, phase-locked at one.
// RL16: In phase-locked mode bit 2 picks feedback from delay line.
// RL17: In delay-locked mode bit 4 selects the doubled output.
// RL18: Global set/reset block bit keeps logic running through chip reset.
// RL19: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module clock_manager_ctrl_regs (
    // Clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          rst_i,
    // Register port
    input  wire clock_manager_pkg::reg_req_type reg_req_i,
    output logic [7:0]                         rdata_o,
    // Chip-wide reset pin, asynchronous
    input  wire logic                          global_set_reset_n_i,
    // Delay line clock as a same-clock tick
    input  wire logic                          delay_line_tick_i,
    // Clock routing controls
    output logic                               edge_clock_en_o,
    output logic                               pll_mode_o,
    output logic                               feedback_from_delay_line_o,
    output logic                               doubled_output_o,
    output clock_manager_pkg::duty_type        duty_o
);
    import clock_manager_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] div_ff;
    logic [7:0] duty2x_ff;
    logic [7:0] duty1x_ff;
    logic [7:0] mode_ff;
    logic [7:0] ctrl_ff;
    logic       gsr_n_meta_ff;
    logic       gsr_n_sync_ff;
    logic       gsr_active;
    logic [3:0] div_val;
    logic [3:0] ratio;
    logic       bypass;
    logic       div_clear;
    logic       div_pulse;
    logic       wr_div;
    logic [7:0] nxt_rdata;
    duty_type   duty_dec;

    assign wr_div = reg_req_i.wr && (reg_req_i.addr == DIV_OFFSET);

    // ************************************************************
    // Global set/reset synchroniser
    // ************************************************************
    // Two stages; only the second one is looked at by logic
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            gsr_n_meta_ff <= 1'b1;
            gsr_n_sync_ff <= 1'b1;
        end else begin
            gsr_n_meta_ff <= global_set_reset_n_i;
            gsr_n_sync_ff <= gsr_n_meta_ff;
        end
    end

    // Blocked chip reset leaves the divider running through a chip reset
    assign gsr_active = !gsr_n_sync_ff &&
                        !ctrl_ff[CTRL_GSR_BLOCK_BIT]; // RL5 RL18

    // ************************************************************
    // Divider register
    // ************************************************************
    // A write with the reset bit set stores default value plus the bit
    always_ff @(posedge clock_i) begin
        if (rst_i || gsr_active) begin // RL5
            div_ff <= DIV_RESET_VAL;
        end else if (wr_div) begin
            if (reg_req_i.wdata[DIV_RESET_BIT]) begin
                div_ff <= DIV_RESET_VAL; // RL4
                div_ff[DIV_RESET_BIT] <= 1'b1; // RL4
            end else begin
                div_ff <= reg_req_i.wdata & DIV_RW_MASK; // RL19
            end
        end
    end

    // ************************************************************
    // Duty registers
    // ************************************************************
    // All eight bits are fields, nothing reserved here
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            duty2x_ff <= DUTY2X_RESET_VAL;
        end else if (reg_req_i.wr && reg_req_i.addr == DUTY2X_OFFSET) begin
            duty2x_ff <= reg_req_i.wdata; // RL8 RL9
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            duty1x_ff <= DUTY1X_RESET_VAL;
        end else if (reg_req_i.wr && reg_req_i.addr == DUTY1X_OFFSET) begin
            duty1x_ff <= reg_req_i.wdata; // RL12 RL14
        end
    end

    // ************************************************************
    // Mode and control registers
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode_ff <= MODE_RESET_VAL;
        end else if (reg_req_i.wr && reg_req_i.addr == MODE_OFFSET) begin
            mode_ff <= reg_req_i.wdata & MODE_RW_MASK; // RL19
        end
    end

    // Not cleared by the chip reset, or the block bit could never work
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_ff <= CTRL_RESET_VAL;
        end else if (reg_req_i.wr && reg_req_i.addr == CTRL_OFFSET) begin
            ctrl_ff <= reg_req_i.wdata & CTRL_RW_MASK; // RL18
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    // Unmapped offsets read as zero; data stands one cycle only
    always_comb begin
        nxt_rdata = READ_IDLE_VAL;
        if (!reg_req_i.rd) begin
            nxt_rdata = READ_IDLE_VAL;
        end else if (reg_req_i.addr == DIV_OFFSET) begin
            nxt_rdata = div_ff & DIV_RW_MASK; // RL19
        end else if (reg_req_i.addr == DUTY2X_OFFSET) begin
            nxt_rdata = duty2x_ff;
        end else if (reg_req_i.addr == DUTY1X_OFFSET) begin
            nxt_rdata = duty1x_ff;
        end else if (reg_req_i.addr == MODE_OFFSET) begin
            nxt_rdata = mode_ff & MODE_RW_MASK; // RL19
        end else if (reg_req_i.addr == CTRL_OFFSET) begin
            nxt_rdata = ctrl_ff & CTRL_RW_MASK;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= READ_IDLE_VAL;
        end else begin
            rdata_o <= nxt_rdata;
        end
    end

    // ************************************************************
    // Edge clock divider
    // ************************************************************
    // Values 9 to 15 wrap to 1 to 7; 8 stays a divide by eight
    assign div_val   = div_ff[DIV_VAL_LSB +: DIV_VAL_W];
    assign bypass    = (div_val == DIV_BYPASS); // RL2
    assign ratio     = (div_val > DIV_WRAP) ?
                       div_val - DIV_WRAP : div_val; // RL3
    assign div_clear = bypass || div_ff[DIV_RESET_BIT]; // RL4

    edge_divider u_edge_divider (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .clear_i (div_clear),
        .ratio_i (ratio),
        .tick_i  (delay_line_tick_i),
        .pulse_o (div_pulse)
    );

    // Bypass skips the counter stage, so it is one cycle earlier
    always_ff @(posedge clock_i) begin
        if (rst_i || gsr_active) begin
            edge_clock_en_o <= 1'b0;
        end else if (bypass) begin
            edge_clock_en_o <= delay_line_tick_i; // RL2
        end else begin
            edge_clock_en_o <= div_pulse; // RL1
        end
    end

    // ************************************************************
    // Loop mode outputs
    // ************************************************************
    // Mode-dependent bits are gated so a stale setting cannot leak
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pll_mode_o                 <= 1'b0;
            feedback_from_delay_line_o <= 1'b0;
            doubled_output_o           <= 1'b0;
        end else begin
            pll_mode_o                 <= mode_ff[MODE_PLL_BIT]; // RL15
            feedback_from_delay_line_o <= mode_ff[MODE_PLL_BIT] &&
                                          mode_ff[MODE_FB_BIT]; // RL16
            doubled_output_o           <= !mode_ff[MODE_PLL_BIT] &&
                                          mode_ff[MODE_2X_BIT]; // RL17
        end
    end

    // ************************************************************
    // Duty outputs
    // ************************************************************
    duty_decoder u_duty_decoder (
        .duty2x_i (duty2x_ff),
        .duty1x_i (duty1x_ff),
        .duty_o   (duty_dec)
    );

    // Registered so routing never sees decoder glitches
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            duty_o <= '0;
        end else begin
            duty_o <= duty_dec; // RL13
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence div_reset_wr_s;
        wr_div && reg_req_i.wdata[DIV_RESET_BIT] && !gsr_active;
    endsequence

    sequence div_release_wr_s;
        wr_div && !reg_req_i.wdata[DIV_RESET_BIT] && !gsr_active;
    endsequence

    div_reset_hold_a: assert property ( // RL4
        @(posedge clock_i) disable iff (rst_i)
        div_reset_wr_s |=> div_ff[DIV_RESET_BIT] && bypass)
        else $error("divider reset bit did not force default");

    div_release_a: assert property ( // RL4
        @(posedge clock_i) disable iff (rst_i)
        div_release_wr_s |=> !div_ff[DIV_RESET_BIT] &&
            div_val == $past(reg_req_i.wdata[DIV_VAL_LSB +: DIV_VAL_W]))
        else $error("divider release write not taken");

    gsr_clear_a: assert property ( // RL5
        @(posedge clock_i) disable iff (rst_i)
        gsr_active |=> div_ff == DIV_RESET_VAL && !edge_clock_en_o)
        else $error("chip reset did not clear divider");

    gsr_block_a: assert property ( // RL18
        @(posedge clock_i) disable iff (rst_i)
        (!gsr_n_sync_ff && ctrl_ff[CTRL_GSR_BLOCK_BIT] && !wr_div)
        |=> $stable(div_ff))
        else $error("blocked chip reset changed divider");

    bypass_path_a: assert property ( // RL2
        @(posedge clock_i) disable iff (rst_i)
        (bypass && !gsr_active) |=>
            edge_clock_en_o == $past(delay_line_tick_i))
        else $error("bypass path not one cycle");

    // A chip reset one cycle after the tick may still cancel the pulse
    divide_path_a: assert property ( // RL2
        @(posedge clock_i) disable iff (rst_i)
        (!bypass && !div_clear && !gsr_active && delay_line_tick_i &&
         ratio == DIV_ONE && !wr_div) ##1 !gsr_active
        |=> edge_clock_en_o)
        else $error("divide by one not two cycles");

    modulo_wrap_a: assert property ( // RL3
        @(posedge clock_i) disable iff (rst_i)
        (div_val == 4'h9) |-> ratio == DIV_ONE)
        else $error("value nine does not divide by one");

    doubled_duty_a: assert property ( // RL9
        @(posedge clock_i) disable iff (rst_i)
        (duty2x_ff == 8'hC9) [*2] |-> duty_o.first_high == 5'h0A &&
            duty_o.second_high == 5'h0A)
        else $error("code C9 not 62.5 percent on both periods");

    first_master_a: assert property ( // RL8
        @(posedge clock_i) disable iff (rst_i)
        ##1 (duty_o.first_high > HALF_IN_16THS) ==
            $past(duty2x_ff[FIRST_MASTER_BIT]))
        else $error("first period range wrong");

    single_low_a: assert property ( // RL13
        @(posedge clock_i) disable iff (rst_i)
        (duty1x_ff[7:6] == 2'h1 && duty1x_ff[2:0] == 3'h4) [*2]
        |-> duty_o.single_high == 6'h0D)
        else $error("code 01xxx100 not 40.625 percent");

    single_delay_a: assert property ( // RL14
        @(posedge clock_i) disable iff (rst_i)
        (duty1x_ff[7:3] == 5'h1E) [*2] |-> duty_o.single_high == 6'h1F)
        else $error("code 11110xxx not 31/32 of a period");

    single_range_a: assert property ( // RL12
        @(posedge clock_i) disable iff (rst_i)
        ##1 (duty_o.single_high[5:3] ==
             {1'b0, $past(duty1x_ff[7:6])}) ||
            (duty_o.single_high[2:0] == 3'h0))
        else $error("single clock outside its quarter range");

    mode_gate_a: assert property ( // RL16
        @(posedge clock_i) disable iff (rst_i)
        ##1 feedback_from_delay_line_o ==
            ($past(mode_ff[MODE_PLL_BIT]) && $past(mode_ff[MODE_FB_BIT])))
        else $error("feedback select not gated by mode");

    doubled_gate_a: assert property ( // RL17
        @(posedge clock_i) disable iff (rst_i)
        pll_mode_o |-> !doubled_output_o)
        else $error("doubled output active in phase-locked mode");

    reserved_read_a: assert property ( // RL19
        @(posedge clock_i) disable iff (rst_i)
        (reg_req_i.rd && reg_req_i.addr == MODE_OFFSET) |=>
            (rdata_o & ~MODE_RW_MASK) == 8'h00 &&
            rdata_o[MODE_PLL_BIT] == $past(mode_ff[MODE_PLL_BIT]))
        else $error("mode read shows reserved bits");

    // Read data stand one cycle only, so a stale word is never re-taken
    read_stand_a: assert property ( // RL19
        @(posedge clock_i) disable iff (rst_i)
        !reg_req_i.rd |=> rdata_o == READ_IDLE_VAL)
        else $error("read data stood past its cycle");

endmodule // clock_manager_ctrl_regs

`default_nettype wire

// *** verification/reg_master_model.sv ***
/*
 * Register master model: the configuration logic on the far side that
 * writes and reads the clock manager registers.
 * Assumes the clock manager's clock and its one-cycle read latency.
 */
`timescale 1ns/1ps
`default_nettype none

module reg_master_model (
    // Clock
    input  wire logic                          clock_i,
    // Register port
    output var  clock_manager_pkg::reg_req_type req_o,
    input  wire logic [7:0]                    rdata_i
);
    import clock_manager_pkg::*;

    // Idle bus from time zero
    initial req_o = '0;

    // One-cycle write; reserved bits are sent as the caller gives them
    task automatic put(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i) req_o <= '{1'b1, 1'b0, a, d};
        // Released address and data show no stale copy
        @(posedge clock_i) req_o <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    // One-cycle read; data taken only in the cycle after the strobe
    task automatic get(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_i) req_o <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock_i) req_o <= '{1'b0, 1'b0, ~a, 8'hFF};
        #1 d = rdata_i;
    endtask
endmodule // reg_master_model

`default_nettype wire

// *** verification/clock_manager_ctrl_regs_tb.sv ***
/*
 * Self-checking bench of the clock manager control registers.
 * Assumes the register master model and a 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module clock_manager_ctrl_regs_tb;
    import clock_manager_pkg::*;

    logic        clock_i, rst_i, gsr_n, tick, edge_en, pll, fb, dbl;
    reg_req_type req;
    logic [7:0]  rdata, rd_v;
    duty_type    duty;
    int          err_total, n_compared, cycles;

    clock_manager_ctrl_regs u_clock_manager_ctrl_regs (
        .clock_i(clock_i), .rst_i(rst_i), .reg_req_i(req), .rdata_o(rdata),
        .global_set_reset_n_i(gsr_n), .delay_line_tick_i(tick),
        .edge_clock_en_o(edge_en), .pll_mode_o(pll),
        .feedback_from_delay_line_o(fb), .doubled_output_o(dbl),
        .duty_o(duty));
    reg_master_model u_reg_master_model (
        .clock_i(clock_i), .req_o(req), .rdata_i(rdata));

    // Clock, and a ceiling well above the few hundred cycles needed
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        u_reg_master_model.get(a, rd_v);
        check("rdata", {8'h00, rd_v}, {8'h00, e});
    endtask
    // Edges until the next edge enable pulse, bounded
    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            @(posedge clock_i);
            #1 n++;
        end while (edge_en !== 1'b1 && n < 20);
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic duty_case(input logic [7:0] r3, r4, input logic [15:0] e);
        u_reg_master_model.put(DUTY2X_OFFSET, r3);
        u_reg_master_model.put(DUTY1X_OFFSET, r4);
        repeat (2) @(posedge clock_i);
        #1 check("duty", duty, e);
        rchk(DUTY2X_OFFSET, r3);
        rchk(DUTY1X_OFFSET, r4);
    endtask
    task automatic mode_case(input logic [7:0] v, input logic [2:0] e);
        u_reg_master_model.put(MODE_OFFSET, v);
        repeat (2) @(posedge clock_i);
        #1 check("mode", {13'h0000, pll, fb, dbl}, {13'h0000, e});
    endtask
    // Spacing of pulses with a tick every cycle; first gaps skipped
    task automatic gap(input logic [7:0] v, input int e);
        int n;
        u_reg_master_model.put(DIV_OFFSET, v);
        repeat (3) wait_pulse(n);
        check("gap", 16'(n), 16'(e));
    endtask
    // One lone tick: bypass answers one edge before divide-by-one
    task automatic lat(input logic [7:0] v, input int e);
        int n;
        u_reg_master_model.put(DIV_OFFSET, v);
        @(posedge clock_i) tick <= 1'b1;
        @(posedge clock_i) tick <= 1'b0;
        #1 n = 0;
        while (edge_en !== 1'b1 && n < 5) begin
            @(posedge clock_i);
            #1 n++;
        end
        check("latency", 16'(n), 16'(e));
    endtask
    task automatic test_reset();
        @(posedge clock_i);
        #1 check("duty0", duty, {5'h01, 5'h01, 6'h01});
        check("mode0", {12'h000, edge_en, pll, fb, dbl}, 16'h0000);
        for (int a = 0; a < 8; a++) rchk(3'(a), 8'h00);
    endtask
    task automatic test_reserved();
        u_reg_master_model.put(DIV_OFFSET, 8'h7F);
        rchk(DIV_OFFSET, 8'h0F);
        u_reg_master_model.put(MODE_OFFSET, 8'hFF);
        rchk(MODE_OFFSET, 8'h15);
        u_reg_master_model.put(CTRL_OFFSET, 8'h7F);
        rchk(CTRL_OFFSET, 8'h00);
        u_reg_master_model.put(3'h6, 8'hFF);
        rchk(3'h6, 8'h00);
    endtask
    task automatic test_gsr();
        u_reg_master_model.put(DIV_OFFSET, 8'h03);
        @(posedge clock_i) gsr_n <= 1'b0;
        repeat (3) @(posedge clock_i);
        repeat (4) begin
            @(posedge clock_i);
            #1 check("edge", {15'h0000, edge_en}, 16'h0000);
        end
        rchk(DIV_OFFSET, 8'h00);
        rchk(MODE_OFFSET, 8'h01);
        @(posedge clock_i) gsr_n <= 1'b1;
        u_reg_master_model.put(CTRL_OFFSET, 8'h80);
        u_reg_master_model.put(DIV_OFFSET, 8'h03);
        @(posedge clock_i) gsr_n <= 1'b0;
        repeat (4) @(posedge clock_i);
        rchk(DIV_OFFSET, 8'h03);
        rchk(CTRL_OFFSET, 8'h80);
        gap(8'h03, 3);
        @(posedge clock_i) gsr_n <= 1'b1;
    endtask

    // Main sequence
    initial begin
        rst_i = 1'b1;
        gsr_n = 1'b1;
        tick = 1'b0;
        err_total = 0;
        n_compared = 0;
        cycles = 0;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        test_reset();
        test_reserved();
        duty_case(8'hC9, 8'h6C, {5'h0A, 5'h0A, 6'h0D});
        duty_case(8'h00, 8'hF7, {5'h01, 5'h01, 6'h1F});
        duty_case(8'h3E, 8'h9A, {5'h07, 5'h08, 6'h14});
        duty_case(8'h47, 8'h38, {5'h10, 5'h01, 6'h01});
        mode_case(8'h01, 3'h4);
        mode_case(8'h05, 3'h6);
        mode_case(8'h14, 3'h1);
        mode_case(8'h11, 3'h4);
        mode_case(8'h00, 3'h0);
        lat(8'h00, 0);
        lat(8'h01, 1);
        @(posedge clock_i) tick <= 1'b1;
        gap(8'h00, 1);
        gap(8'h03, 3);
        gap(8'h08, 8);
        gap(8'h09, 1);
        gap(8'h0F, 7);
        gap(8'h85, 1);
        rchk(DIV_OFFSET, 8'h80);
        gap(8'h05, 5);
        u_reg_master_model.put(MODE_OFFSET, 8'h01);
        test_gsr();
        close_out();
    end
endmodule // clock_manager_ctrl_regs_tb

`default_nettype wire
